// [verilog/spc_codec.sv]
// Surveillance parity codec: encoder, detector and error corrector.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// How it works
// - 24-stage encoder register with polynomial feedback taps
// - Mode switch: information field or address/parity
// - Encoder register cleared before every message
// - Information bits pass through; register divides
// - Parity from sum network; ground feeds address in
// - Transponder parity field feeds register with zero
// - Received bits shift into register and buffer
// - Transponder accepts only when remainder equals address
// - Ground syndrome: remainder plus address; zero passes
// - Confidence bit stored alongside each message bit
// - Load syndrome, confidence and message for correction
// - Each step advances syndrome, rotates message, confidence
// - Trapped syndrome sets correction enable, stops search
// - Trapped syndrome shifts out, flipping matching bits
// - Too many low-confidence bits per window rejects
// - Conservative: one window, at most twelve bits
// - Conservative: syndrome must fit window, else stop
// - Brute force: exactly one matching subset corrects
// - Brute force only after failed conservative try
// - Per-position syndrome table, subsets combine by XOR
// - Brute force skipped above five low-confidence bits
// - Generator degree 24, terms 0,3,10,12-24
module spc_codec
  import spc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Bit stream from the far side
  input  wire logic        som_i,
  input  wire logic        bit_vld_i,
  input  wire logic        bit_i,
  input  wire logic        conf_i,
  // Bit stream and status out
  output logic             out_bit_o,
  output logic             out_vld_o,
  output logic             done_o,
  output logic      [1:0]  result_o,
  output logic             busy_o
);

  spc_state_t           q;
  spc_state_t           d;
  logic [6:0]           n_len;
  logic [6:0]           rot_nx;
  logic                 fb;
  logic                 in_par;
  logic                 a_bit;
  logic                 last;
  logic [23:0]          win;
  logic [4:0]           wlc;
  logic                 trap;
  logic                 over;
  logic                 inwin;
  logic                 xp_ok;
  logic [23:0]          esr_adv;
  logic [23:0]          bf_acc;
  logic [5:0]           sub_end;
  logic [BF_N-1:0][6:0] xpos;

  // Rotates a message-wide word right within the active length.
  function automatic logic [MSG_W-1:0] rotr(
    input logic [MSG_W-1:0] m,
    input logic             top,
    input logic             lng
  );
    rotr = lng ? {top, m[MSG_W-1:1]}
               : {m[MSG_W-1:SHORT_W], top, m[SHORT_W-1:1]};
  endfunction

  function automatic logic [4:0] pop24(input logic [23:0] v);
    pop24 = 5'h00;
    for (int i = 0; i < PW; i++) begin
      pop24 = pop24 + 5'(v[i]);
    end
  endfunction

  always_comb begin
    d       = q;
    d.done  = 1'b0;
    d.ovld  = 1'b0;
    d.rdata = 32'h0;
    n_len   = q.cfg.lng ? N_LONG : N_SHORT;
    rot_nx  = (q.rot == n_len - 7'h01) ? 7'h00 : q.rot + 7'h01;
    fb      = ^(q.sr & M_TAPS);
    in_par  = q.cnt >= n_len - PW7;
    a_bit   = q.cfg.addr[5'(n_len - 7'h01 - q.cnt)];
    last    = q.cnt == n_len - 7'h01;
    win     = q.conf[23:0];
    wlc     = pop24(win);
    trap    = (q.esr & ~win) == 24'h0;
    over    = wlc > q.cfg.thr;
    inwin   = {2'b00, wlc} == q.lc_tot;
    xp_ok   = q.sr == q.cfg.addr;
    // Reciprocal-form step: divide the syndrome by x modulo G.
    esr_adv = q.esr[0] ? {1'b1, q.esr[23:1] ^ G_LOW[23:1]}
                       : {1'b0, q.esr[23:1]};
    sub_end = 6'((7'h01 << q.lc_tot[2:0]) - 7'h01);
    bf_acc  = 24'h0;
    for (int i = 0; i < BF_N; i++) begin
      xpos[i] = n_len - 7'h01 - q.lc_pos[i];
      if (3'(i) < q.lc_tot[2:0] && q.sub[i]) begin
        bf_acc = bf_acc ^ SYN_TAB[xpos[i]];
      end
    end

    if (wr_i) begin
      case (addr_i)
        A_CTRL: begin
          d.reg_cfg.enc  = wdata_i[C_ENC];
          d.reg_cfg.gnd  = wdata_i[C_GND];
          d.reg_cfg.lng  = wdata_i[C_LNG];
          d.reg_cfg.meth = spc_meth_t'(wdata_i[C_METH+:2]);
        end
        A_ADDR:  d.reg_cfg.addr = wdata_i[23:0];
        A_THR:   d.reg_cfg.thr  = wdata_i[4:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        A_CTRL:  d.rdata = 32'({q.reg_cfg.meth, q.reg_cfg.lng,
                                q.reg_cfg.gnd, q.reg_cfg.enc});
        A_ADDR:  d.rdata = 32'(q.reg_cfg.addr);
        A_THR:   d.rdata = 32'(q.reg_cfg.thr);
        A_STAT:  d.rdata = 32'({q.busy, q.res, q.lc_tot});
        A_SYN:   d.rdata = 32'(q.syn0);
        default: d.rdata = 32'h0;
      endcase
    end

    case (q.st)
      S_IDLE: begin
        if (som_i) begin
          d.cfg        = q.reg_cfg;
          d.sr         = 24'h0;
          d.rem        = 24'h0;
          d.msg        = '0;
          d.conf       = '0;
          d.cnt        = 7'h00;
          d.rot        = 7'h00;
          d.lc_tot     = 7'h00;
          d.hits       = 2'b00;
          d.cons_tried = 1'b0;
          d.to_bf      = 1'b0;
          d.res        = R_NONE;
          d.st         = q.reg_cfg.enc ? S_ENC : S_RECV;
        end
      end
      S_ENC: begin
        if (bit_vld_i) begin
          d.ovld = 1'b1;
          d.cnt  = q.cnt + 7'h01;
          if (in_par) begin
            d.obit = fb ^ a_bit;
            d.sr   = {q.sr[22:0], q.cfg.gnd & a_bit};
          end else begin
            d.obit = bit_i;
            d.sr   = {q.sr[22:0], bit_i ^ fb};
          end
          if (last) begin
            d.res = R_OK;
            d.st  = S_DONE;
          end
        end
      end
      S_RECV: begin
        if (bit_vld_i) begin
          d.msg  = {q.msg[MSG_W-2:0], bit_i};
          d.conf = {q.conf[MSG_W-2:0], conf_i};
          d.sr   = {q.sr[22:0], bit_i ^ fb};
          d.rem  = {q.rem[22:0], bit_i} ^ (q.rem[23] ? G_LOW : 24'h0);
          if (conf_i) begin
            if (q.lc_tot < BF_MX) begin
              d.lc_pos[q.lc_tot[2:0]] = q.cnt;
            end
            d.lc_tot = q.lc_tot + 7'h01;
          end
          d.cnt = q.cnt + 7'h01;
          if (last) begin
            d.cnt = 7'h00;
            d.st  = S_EVAL;
          end
        end
      end
      S_EVAL: begin
        d.cnt = 7'h00;
        if (!q.cfg.gnd) begin
          d.res = xp_ok ? R_OK : R_REJ;
          d.st  = xp_ok ? S_OUT : S_DONE;
        end else begin
          d.syn0 = q.rem ^ q.cfg.addr;
          d.esr  = q.rem ^ q.cfg.addr;
          if (q.rem == q.cfg.addr) begin
            d.res = R_OK;
            d.st  = S_OUT;
          end else if (q.cfg.meth == M_SLIDE) begin
            d.st = S_SRCH;
          end else if (q.lc_tot != 7'h00 && q.lc_tot <= CONS_MX) begin
            d.cons_tried = 1'b1;
            d.st         = S_SRCH;
          end else begin
            d.res = R_REJ;
            d.st  = S_DONE;
          end
        end
      end
      S_SRCH: begin
        d.msg  = rotr(q.msg, q.msg[0], q.cfg.lng);
        d.conf = rotr(q.conf, q.conf[0], q.cfg.lng);
        d.esr  = esr_adv;
        d.cnt  = q.cnt + 7'h01;
        d.rot  = rot_nx;
        if (q.cfg.meth == M_SLIDE) begin
          if (over) begin
            d.res = R_REJ;
            d.st  = S_DONE;
          end else if (trap) begin
            d.msg = q.msg;
            d.conf = q.conf;
            d.esr = q.esr;
            d.rot = q.rot;
            d.cnt = 7'h00;
            d.st  = S_FIX;
          end else if (q.cnt == n_len - PW7) begin
            d.res = R_REJ;
            d.st  = S_DONE;
          end
        end else if (inwin && !over && trap) begin
          d.msg = q.msg;
          d.conf = q.conf;
          d.esr = q.esr;
          d.rot = q.rot;
          d.cnt = 7'h00;
          d.st  = S_FIX;
        end else if (inwin || q.cnt == n_len - PW7) begin
          d.msg  = q.msg;
          d.conf = q.conf;
          d.rot  = q.rot;
          if (q.cfg.meth == M_BRUTE && q.lc_tot <= BF_MX) begin
            d.to_bf = 1'b1;
            d.st    = S_ALGN;
          end else begin
            d.res = R_REJ;
            d.st  = S_DONE;
          end
        end
      end
      S_FIX: begin
        d.msg  = rotr(q.msg, q.msg[0] ^ q.esr[0], q.cfg.lng);
        d.conf = rotr(q.conf, q.conf[0], q.cfg.lng);
        d.esr  = {1'b0, q.esr[23:1]};
        d.rot  = rot_nx;
        d.cnt  = q.cnt + 7'h01;
        if (q.cnt == PW7 - 7'h01) begin
          d.res = R_FIX;
          d.st  = S_ALGN;
        end
      end
      S_ALGN: begin
        if (q.rot == 7'h00) begin
          d.cnt  = 7'h00;
          d.sub  = 6'h01;
          d.hits = 2'b00;
          d.st   = q.to_bf ? S_BF : S_OUT;
        end else begin
          d.msg  = rotr(q.msg, q.msg[0], q.cfg.lng);
          d.conf = rotr(q.conf, q.conf[0], q.cfg.lng);
          d.rot  = rot_nx;
        end
      end
      S_BF: begin
        if (bf_acc == q.syn0) begin
          d.hits    = (q.hits == 2'b10) ? q.hits : q.hits + 2'b01;
          d.hit_sub = q.sub[BF_N-1:0];
        end
        d.sub = q.sub + 6'h01;
        if (q.sub == sub_end) begin
          d.st = S_BAPP;
        end
      end
      S_BAPP: begin
        if (q.hits == 2'b01) begin
          for (int i = 0; i < BF_N; i++) begin
            if (3'(i) < q.lc_tot[2:0] && q.hit_sub[i]) begin
              d.msg[xpos[i]] = ~q.msg[xpos[i]];
            end
          end
          d.res = R_FIX;
          d.st  = S_OUT;
        end else begin
          d.res = R_REJ;
          d.st  = S_DONE;
        end
      end
      S_OUT: begin
        d.ovld = 1'b1;
        d.obit = q.msg[n_len - 7'h01 - q.cnt];
        d.cnt  = q.cnt + 7'h01;
        if (last) begin
          d.st = S_DONE;
        end
      end
      S_DONE: begin
        d.done = 1'b1;
        d.st   = S_IDLE;
      end
      default: d.st = S_IDLE;
    endcase

    d.busy = d.st != S_IDLE;
    if (srst_i) begin
      d             = '0;
      d.reg_cfg.thr = THR_RST;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  assign rdata_o   = q.rdata;
  assign out_bit_o = q.obit;
  assign out_vld_o = q.ovld;
  assign done_o    = q.done;
  assign result_o  = q.res;
  assign busy_o    = q.busy;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_enc_clear :
  assert property (q.st == S_IDLE && som_i |=> q.sr == 24'h0)
  else $error("encoder register not cleared at start");
  chk_enc_pass :
  assert property (q.st == S_ENC && bit_vld_i && !in_par
                   |=> q.ovld && q.obit == $past(bit_i))
  else $error("information bit not passed through");
  chk_par_out :
  assert property (q.st == S_ENC && bit_vld_i && in_par && q.cfg.gnd
                   |=> q.sr[0] == $past(a_bit))
  else $error("ground encoder did not feed address bit");
  chk_xpdr_zero :
  assert property (q.st == S_ENC && bit_vld_i && in_par && !q.cfg.gnd
                   |=> q.sr == {$past(q.sr[22:0]), 1'b0})
  else $error("transponder register input not zero");
  chk_xpdr_match :
  assert property (q.st == S_EVAL && !q.cfg.gnd
                   |=> q.res == ($past(xp_ok) ? R_OK : R_REJ))
  else $error("transponder acceptance wrong");
  chk_syn_pass :
  assert property (q.st == S_EVAL && q.cfg.gnd && q.rem == q.cfg.addr
                   |=> q.st == S_OUT && q.res == R_OK)
  else $error("zero syndrome not passed");
  chk_trap_fix :
  assert property (q.st == S_SRCH && q.cfg.meth == M_SLIDE && !over
                   && trap |=> q.st == S_FIX ##24 q.st == S_ALGN)
  else $error("trapped error not corrected in 24 steps");
  chk_fix_nofb :
  assert property (q.st == S_FIX |=> q.esr == {1'b0, $past(q.esr[23:1])})
  else $error("syndrome feedback active while correcting");
  chk_thr_rej :
  assert property (q.st == S_SRCH && q.cfg.meth == M_SLIDE && over
                   |=> q.st == S_DONE && q.res == R_REJ)
  else $error("threshold overrun not rejected");
  chk_bf_after :
  assert property (q.st == S_BF |-> q.cons_tried && q.lc_tot <= BF_MX)
  else $error("brute force entered without conservative try");
  chk_bf_unique :
  assert property (q.st == S_BAPP && q.hits != 2'b01
                   |=> q.st == S_DONE && q.res == R_REJ)
  else $error("ambiguous brute force not rejected");
  chk_done_pulse :
  assert property (q.done |=> !q.done && q.st == S_IDLE)
  else $error("done not a single pulse");

  cov_enc_done : cover property (q.st == S_ENC ##2 q.done);
  cov_slide_fix : cover property (q.st == S_FIX && q.cfg.meth == M_SLIDE);
  cov_bf_fix : cover property (q.st == S_BAPP && q.hits == 2'b01);
  cov_reject : cover property (q.done && q.res == R_REJ);
endmodule

// [verilog/spc_pkg.sv]
// Constants, types and the syndrome table of the parity codec.
package spc_pkg;
  localparam int          MSG_W   = 112;
  localparam int          SHORT_W = 56;
  localparam int          PW      = 24;
  localparam int          BF_N    = 5;
  localparam logic [6:0]  N_LONG  = 7'(MSG_W);
  localparam logic [6:0]  N_SHORT = 7'(SHORT_W);
  localparam logic [6:0]  PW7     = 7'(PW);
  localparam logic [6:0]  BF_MX   = 7'(BF_N);
  localparam logic [6:0]  CONS_MX = 7'h0C;
  // Generator below x^24, and its terms mirrored as multiplier taps.
  localparam logic [23:0] G_LOW   = 24'hFFF409;
  localparam logic [23:0] M_TAPS  = 24'h902FFF;
  localparam logic [7:0]  A_CTRL  = 8'h00;
  localparam logic [7:0]  A_ADDR  = 8'h04;
  localparam logic [7:0]  A_THR   = 8'h08;
  localparam logic [7:0]  A_STAT  = 8'h0C;
  localparam logic [7:0]  A_SYN   = 8'h10;
  localparam int          C_ENC   = 0;
  localparam int          C_GND   = 1;
  localparam int          C_LNG   = 2;
  localparam int          C_METH  = 3;
  localparam logic [4:0]  THR_RST = 5'h0C;

  typedef enum logic [1:0] {
    M_SLIDE = 2'b00,
    M_CONS  = 2'b01,
    M_BRUTE = 2'b10
  } spc_meth_t;

  typedef enum logic [1:0] {
    R_NONE = 2'b00,
    R_OK   = 2'b01,
    R_FIX  = 2'b10,
    R_REJ  = 2'b11
  } spc_res_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ENC  = 4'h1,
    S_RECV = 4'h2,
    S_EVAL = 4'h3,
    S_SRCH = 4'h4,
    S_FIX  = 4'h5,
    S_ALGN = 4'h6,
    S_BF   = 4'h7,
    S_BAPP = 4'h8,
    S_OUT  = 4'h9,
    S_DONE = 4'hA
  } spc_st_t;

  typedef struct packed {
    logic        enc;
    logic        gnd;
    logic        lng;
    spc_meth_t   meth;
    logic [4:0]  thr;
    logic [23:0] addr;
  } spc_cfg_t;

  typedef struct packed {
    spc_st_t               st;
    spc_cfg_t              reg_cfg;
    spc_cfg_t              cfg;
    logic [MSG_W-1:0]      msg;
    logic [MSG_W-1:0]      conf;
    logic [23:0]           sr;
    logic [23:0]           rem;
    logic [23:0]           syn0;
    logic [23:0]           esr;
    logic [6:0]            cnt;
    logic [6:0]            rot;
    logic [6:0]            lc_tot;
    logic [BF_N-1:0][6:0]  lc_pos;
    logic [5:0]            sub;
    logic [1:0]            hits;
    logic [BF_N-1:0]       hit_sub;
    logic                  cons_tried;
    logic                  to_bf;
    spc_res_t              res;
    logic                  done;
    logic                  busy;
    logic                  obit;
    logic                  ovld;
    logic [31:0]           rdata;
  } spc_state_t;

  typedef logic [MSG_W-1:0][23:0] spc_tab_t;

  // Entry k is the syndrome of a lone error at power x^k.
  function automatic spc_tab_t spc_mk_tab();
    spc_tab_t    t;
    logic [23:0] s;
    s = 24'h000001;
    for (int k = 0; k < MSG_W; k++) begin
      t[k] = s;
      s = s[23] ? {s[22:0], 1'b0} ^ G_LOW : {s[22:0], 1'b0};
    end
    return t;
  endfunction

  localparam spc_tab_t SYN_TAB = spc_mk_tab();
endpackage

// [tb/spc_far_end.sv]
// Far-side bit source model: start strobe, then one strobe per message bit.
`timescale 1ns/100ps
module spc_far_end (
  // Clock
  input  wire logic sys_clk_i,
  // Bit stream towards the codec
  output logic      som_o,
  output logic      bit_vld_o,
  output logic      bit_o,
  output logic      conf_o
);
  initial begin
    som_o = 1'b0;
    bit_vld_o = 1'b0;
    bit_o = 1'b0;
    conf_o = 1'b0;
  end

  // Bits go out in bursts with gaps; in a gap the lines show the inverse
  // of the last value, so sampling without the strobe picks up wrong data.
  task automatic send(input logic [111:0] m, input logic [111:0] c,
                      input int n);
    @(posedge sys_clk_i);
    som_o <= 1'b1;
    @(posedge sys_clk_i);
    som_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      bit_vld_o <= 1'b1;
      bit_o <= m[i];
      conf_o <= c[i];
      @(posedge sys_clk_i);
      if (i % 3 == 1 || i == 0) begin
        bit_vld_o <= 1'b0;
        bit_o <= ~m[i];
        conf_o <= ~c[i];
        if (i != 0) @(posedge sys_clk_i);
      end
    end
  endtask
endmodule

// [tb/test_spc_codec.sv]
// Bench for the parity codec: registers, encoder, detector and corrector.
`timescale 1ns/100ps
module test_spc_codec
  import spc_pkg::*;
;
  logic         sys_clk_i;
  logic         srst_i;
  logic [7:0]   addr_i;
  logic [31:0]  wdata_i;
  logic         wr_i;
  logic         rd_i;
  logic [31:0]  rdata_o;
  logic         som_i;
  logic         bit_vld_i;
  logic         bit_i;
  logic         conf_i;
  logic         out_bit_o;
  logic         out_vld_o;
  logic         done_o;
  logic [1:0]   result_o;
  logic         busy_o;
  int           fails;
  int           samples_checked;
  int           cycles;
  int           ocnt;
  int           dcnt;
  logic [111:0] obuf;
  logic [1:0]   rdone;
  logic [31:0]  rd;

  spc_codec spc_codec_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .som_i(som_i), .bit_vld_i(bit_vld_i), .bit_i(bit_i),
    .conf_i(conf_i), .out_bit_o(out_bit_o), .out_vld_o(out_vld_o),
    .done_o(done_o), .result_o(result_o), .busy_o(busy_o)
  );

  spc_far_end spc_far_end_i (
    .sys_clk_i(sys_clk_i), .som_o(som_i), .bit_vld_o(bit_vld_i),
    .bit_o(bit_i), .conf_o(conf_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("unexpected at %0t: run too long", $time);
      report_and_stop();
    end
  end

  // Collects output bits and the result seen with the done pulse.
  always @(posedge sys_clk_i) begin
    if (out_vld_o === 1'b1) begin
      obuf = {obuf[110:0], out_bit_o};
      ocnt++;
    end
    if (done_o === 1'b1) begin
      dcnt++;
      rdone = result_o;
    end
  end

  task automatic check(input logic [111:0] seen, input logic [111:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen,
               exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // One message through the block; waits for done and checks the pulse.
  task automatic msg(input logic [4:0] ctrl, input logic [23:0] ad,
                     input logic [111:0] m, input logic [111:0] c);
    int n;
    int k;
    n = ctrl[2] ? 112 : 56;
    reg_wr(A_CTRL, 32'(ctrl));
    reg_wr(A_ADDR, 32'(ad));
    obuf = '0;
    ocnt = 0;
    dcnt = 0;
    spc_far_end_i.send(m, c, n);
    #1;
    check(112'(busy_o), 112'h1, "busy");
    k = 0;
    while (dcnt == 0 && k < 3000) begin
      @(posedge sys_clk_i);
      k++;
    end
    repeat (3) @(posedge sys_clk_i);
    #1;
    check(112'(dcnt), 112'h1, "done pulses");
    check(112'(result_o), 112'(rdone), "result held");
  endtask

  task automatic expect_res(input spc_res_t r, input int bits);
    check(112'(rdone), 112'(r), "result");
    check(112'(ocnt), 112'(bits), "output bits");
  endtask

  task automatic t_regs();
    reg_rd(A_THR, rd);
    check(112'(rd), 112'(THR_RST), "threshold reset");
    reg_rd(A_CTRL, rd);
    check(112'(rd), 112'h0, "control reset");
    reg_rd(8'h14, rd);
    check(112'(rd), 112'h0, "unmapped read");
    reg_wr(A_ADDR, 32'hFFABCDEF);
    reg_rd(A_ADDR, rd);
    check(112'(rd), 112'hABCDEF, "address readback");
    @(posedge sys_clk_i);
    #1;
    check(112'(rdata_o), 112'h0, "read data one cycle");
    $display("test regs done");
  endtask

  task automatic t_encode();
    logic [111:0] e1;
    logic [111:0] e2;
    logic [111:0] inf;
    inf = {56'h0, 32'hC0FFEE35, 24'h0};
    msg(5'h01, 24'h5A3C96, inf, '0);
    e1 = obuf;
    check(112'(e1[55:24]), 112'hC0FFEE35, "info passes");
    expect_res(R_OK, 56);
    msg(5'h01, 24'h5A3C96, '0, '0);
    check(obuf, 112'h5A3C96, "parity of zero info");
    msg(5'h02, 24'h5A3C96, e1, '0);
    expect_res(R_OK, 56);
    check(obuf, e1, "passed message");
    reg_rd(A_SYN, rd);
    check(112'(rd), 112'h0, "zero syndrome");
    msg(5'h03, 24'h5A3C96, inf, '0);
    e2 = obuf;
    msg(5'h00, 24'h5A3C96, e2, '0);
    expect_res(R_OK, 56);
    check(obuf, e2, "buffered message");
    msg(5'h00, 24'h5A3C97, e2, '0);
    expect_res(R_REJ, 0);
    $display("test encode done");
  endtask

  task automatic t_slide();
    logic [6:0]   pos [3];
    logic [23:0]  syn [3];
    logic [111:0] m;
    pos = '{7'h6F, 7'h51, 7'h01};
    syn = '{24'h3935EA, 24'hFDB444, 24'h000002};
    for (int i = 0; i < 3; i++) begin
      m = 112'h1 << pos[i];
      msg(5'h06, 24'h0, m, m);
      reg_rd(A_SYN, rd);
      check(112'(rd), 112'(syn[i]), "syndrome");
      expect_res(R_FIX, 112);
      check(obuf, 112'h0, "corrected bits");
    end
    reg_wr(A_THR, 32'h2);
    msg(5'h06, 24'h0, 112'h2, 112'hE);
    expect_res(R_REJ, 0);
    reg_wr(A_THR, 32'(THR_RST));
    $display("test slide done");
  endtask

  task automatic t_cons();
    reg_wr(A_THR, 32'h1F);
    msg(5'h0E, 24'h0, 112'h2, 112'h1FFE);
    expect_res(R_FIX, 112);
    check(obuf, 112'h0, "conservative fix");
    reg_rd(A_STAT, rd);
    check(112'(rd), 112'h10C, "status word");
    msg(5'h0E, 24'h0, 112'h2, 112'h3FFE);
    expect_res(R_REJ, 0);
    msg(5'h0E, 24'h0, 112'h2, 112'h3C);
    expect_res(R_REJ, 0);
    reg_wr(A_THR, 32'(THR_RST));
    $display("test conservative done");
  endtask

  task automatic t_brute();
    logic [111:0] m;
    logic [111:0] c;
    m = {1'b1, 29'h0, 1'b1, 79'h0, 1'b1, 1'b0};
    msg(5'h0E, 24'h0, m, m);
    expect_res(R_REJ, 0);
    msg(5'h16, 24'h0, m, m);
    reg_rd(A_SYN, rd);
    check(112'(rd), 112'hC481AC, "combined syndrome");
    expect_res(R_FIX, 112);
    check(obuf, 112'h0, "brute fix");
    c = m | (112'h1 << 7'h32) | (112'h1 << 7'h1E);
    msg(5'h16, 24'h0, m, c);
    expect_res(R_FIX, 112);
    c = c | (112'h1 << 7'h46);
    msg(5'h16, 24'h0, m, c);
    expect_res(R_REJ, 0);
    $display("test brute done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    ocnt = 0;
    dcnt = 0;
    obuf = '0;
    rdone = 2'h0;
    srst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    t_regs();
    t_encode();
    t_slide();
    t_cons();
    t_brute();
    report_and_stop();
  end
endmodule
